// File: common/aab_pkg.sv
// Constants, field layouts and types of the accumulator datapath
package aab_pkg;

  // Register offsets (byte addresses on the bus)
  localparam logic [31:0] AAB_OFS_CMD        = 32'h0000_0000;
  localparam logic [31:0] AAB_OFS_STAT       = 32'h0000_0004;
  localparam logic [31:0] AAB_OFS_FILE_BASE  = 32'h0000_0200;
  localparam logic [31:0] AAB_OFS_FILE_LAST  = 32'h0000_03FC;

  // Command word fields
  localparam int AAB_CMD_OP_LSB   = 0;
  localparam int AAB_CMD_TGT_BIT  = 3;
  localparam int AAB_CMD_BIT_LSB  = 4;
  localparam int AAB_CMD_ADDR_LSB = 8;
  localparam int AAB_CMD_LIT_LSB  = 16;

  // Status word fields
  localparam int AAB_STAT_ACC_LSB = 0;
  localparam int AAB_STAT_CARRY   = 8;
  localparam int AAB_STAT_NIBBLE  = 9;
  localparam int AAB_STAT_ZERO    = 10;
  localparam int AAB_STAT_BUSY    = 11;
  localparam int AAB_STAT_ARMED   = 12;

  // Reset values
  localparam logic [7:0] AAB_ACC_RST = 8'h00;
  localparam logic [7:0] AAB_REG_RST = 8'h00;

  // Sizes and timing
  localparam int AAB_NREGS         = 128;
  localparam int AAB_OSC_PER_CYCLE = 4;

  typedef enum logic [2:0] {
    IDLE_INSTRUCTION,
    ADD_LITERAL_OP,
    ADD_REGISTER_OP,
    MASK_LITERAL_OP,
    MASK_REGISTER_OP,
    BIT_CLEAR_OP,
    BIT_SET_OP,
    TEST_SKIP_IF_ONE_OP
  } aab_op_e;

  typedef struct packed {
    logic [7:0] literal;
    logic [6:0] addr;
    logic [2:0] bitPos;
    logic       target;
    aab_op_e    op;
  } aab_cmd_s;

endpackage

// File: logic/aab_core.sv
// Accumulator add, mask and bit datapath with an AHB-Lite register slave
// How it works
// RQ1 - Add-literal adds the literal into the accumulator and updates carry, nibble and zero.
// RQ2 - Add-register writes accumulator plus register to either by target, updating all flags.
// RQ3 - Mask-literal ANDs the literal into the accumulator and updates only zero.
// RQ4 - Mask-register ANDs accumulator and register into either by target, updating only zero.
// RQ5 - Bit-clear zeroes one bit of the addressed register and touches no other bit or flag.
// RQ6 - Bit-set sets one bit of the addressed register and touches no other bit or flag.
// RQ7 - A skip test that finds its bit at one turns the next instruction into an idle cycle.
// RQ8 - A skip test finding its bit at zero lets the next instruction run and changes no flag.
// RQ9 - An instruction cycle spans four oscillator periods; a skip adds a second, idle cycle.
// RQ10 - Carry is the bit 7 carry out, nibble overflow the bit 3 one, zero means a zero result.
module aab_core
  import aab_pkg::*;
#(
  parameter int OSC_PER_CYCLE = AAB_OSC_PER_CYCLE
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp
);

  if (OSC_PER_CYCLE < 2 || OSC_PER_CYCLE > 16) begin : gBadDiv
    $error("OSC_PER_CYCLE must lie between 2 and 16");
  end

  typedef struct packed {
    logic [AAB_NREGS-1:0][7:0] regs;
    aab_cmd_s                  cmd;
    logic                      pending;
    logic                      armed;
    logic [7:0]                acc;
    logic                      carry;
    logic                      nibbleOverflowFlag;
    logic                      zero;
    logic [3:0]                div;
    logic                      dph;
    logic                      dphWrite;
    logic [31:0]               dphAddr;
  } aab_state_s;

  aab_state_s st;
  aab_state_s next_st;
  logic       tick;
  logic       doExec;
  aab_op_e    execOp;
  logic [7:0] operand;
  logic [8:0] sum;
  logic [4:0] nibSum;
  logic [7:0] result;

  function automatic logic fileHit(input logic [31:0] a);
    return a >= AAB_OFS_FILE_BASE && a <= AAB_OFS_FILE_LAST && a[1:0] == 2'b00;
  endfunction

  function automatic logic [6:0] fileIdx(input logic [31:0] a);
    return 7'((a - AAB_OFS_FILE_BASE) >> 2);
  endfunction

  always_comb begin
    next_st = st;
    tick    = st.div == 4'(OSC_PER_CYCLE - 1);
    next_st.div = tick ? 4'h0 : st.div + 4'h1; // RQ9
    operand = st.regs[st.cmd.addr];
    sum     = 9'h000;
    nibSum  = 5'h00;
    result  = 8'h00;
    doExec  = tick && st.pending;
    // Armed skip swaps the next instruction for an idle cycle
    execOp  = st.armed ? IDLE_INSTRUCTION : st.cmd.op; // RQ7
    // Bus data phase; writes are refused while an instruction waits
    if (st.dph && st.dphWrite && !st.pending) begin
      if (st.dphAddr == AAB_OFS_CMD) begin
        // Fields picked by position; the word has spare bits between them
        next_st.cmd.op      = aab_op_e'(hwdata[AAB_CMD_OP_LSB +: 3]);
        next_st.cmd.target  = hwdata[AAB_CMD_TGT_BIT];
        next_st.cmd.bitPos  = hwdata[AAB_CMD_BIT_LSB +: 3];
        next_st.cmd.addr    = hwdata[AAB_CMD_ADDR_LSB +: 7];
        next_st.cmd.literal = hwdata[AAB_CMD_LIT_LSB +: 8];
        next_st.pending     = 1'b1;
      end else if (st.dphAddr == AAB_OFS_STAT) begin
        next_st.acc                = hwdata[AAB_STAT_ACC_LSB +: 8];
        next_st.carry              = hwdata[AAB_STAT_CARRY];
        next_st.nibbleOverflowFlag = hwdata[AAB_STAT_NIBBLE];
        next_st.zero               = hwdata[AAB_STAT_ZERO];
      end else if (fileHit(st.dphAddr)) begin
        next_st.regs[fileIdx(st.dphAddr)] = hwdata[7:0];
      end
    end
    next_st.dph      = hsel && htrans[1] && hready;
    next_st.dphWrite = hwrite;
    next_st.dphAddr  = haddr;
    if (doExec) begin
      next_st.pending = 1'b0;
      next_st.armed   = 1'b0;
      unique case (execOp)
        ADD_LITERAL_OP, ADD_REGISTER_OP: begin
          sum    = {1'b0, st.acc} + {1'b0, execOp == ADD_LITERAL_OP ? st.cmd.literal : operand};
          nibSum = {1'b0, st.acc[3:0]} + {1'b0, execOp == ADD_LITERAL_OP ?
                   st.cmd.literal[3:0] : operand[3:0]};
          result = sum[7:0];
          next_st.carry              = sum[8]; // RQ10
          next_st.nibbleOverflowFlag = nibSum[4]; // RQ10
          next_st.zero               = result == 8'h00; // RQ10
          if (execOp == ADD_REGISTER_OP && st.cmd.target) begin
            next_st.regs[st.cmd.addr] = result; // RQ2
          end else begin
            next_st.acc = result; // RQ1
          end
        end
        MASK_LITERAL_OP, MASK_REGISTER_OP: begin
          result = st.acc & (execOp == MASK_LITERAL_OP ? st.cmd.literal : operand);
          next_st.zero = result == 8'h00; // RQ3
          if (execOp == MASK_REGISTER_OP && st.cmd.target) begin
            next_st.regs[st.cmd.addr] = result; // RQ4
          end else begin
            next_st.acc = result; // RQ3
          end
        end
        BIT_CLEAR_OP: begin
          next_st.regs[st.cmd.addr][st.cmd.bitPos] = 1'b0; // RQ5
        end
        BIT_SET_OP: begin
          next_st.regs[st.cmd.addr][st.cmd.bitPos] = 1'b1; // RQ6
        end
        TEST_SKIP_IF_ONE_OP: begin
          next_st.armed = operand[st.cmd.bitPos]; // RQ7 RQ8
        end
        IDLE_INSTRUCTION: begin
          next_st.armed = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st         <= '0;
      st.regs    <= {AAB_NREGS{AAB_REG_RST}};
      st.acc     <= AAB_ACC_RST;
      st.cmd.op  <= IDLE_INSTRUCTION;
    end else begin
      st <= next_st;
    end
  end

  // Zero wait states: every register is a plain flop, so no stall is needed
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_comb begin
    hrdata = 32'h0000_0000;
    if (st.dph && !st.dphWrite) begin
      if (st.dphAddr == AAB_OFS_CMD) begin
        hrdata[AAB_CMD_OP_LSB +: 3]   = st.cmd.op;
        hrdata[AAB_CMD_TGT_BIT]       = st.cmd.target;
        hrdata[AAB_CMD_BIT_LSB +: 3]  = st.cmd.bitPos;
        hrdata[AAB_CMD_ADDR_LSB +: 7] = st.cmd.addr;
        hrdata[AAB_CMD_LIT_LSB +: 8]  = st.cmd.literal;
      end else if (st.dphAddr == AAB_OFS_STAT) begin
        hrdata[AAB_STAT_ACC_LSB +: 8] = st.acc;
        hrdata[AAB_STAT_CARRY]        = st.carry;
        hrdata[AAB_STAT_NIBBLE]       = st.nibbleOverflowFlag;
        hrdata[AAB_STAT_ZERO]         = st.zero;
        hrdata[AAB_STAT_BUSY]         = st.pending;
        hrdata[AAB_STAT_ARMED]        = st.armed;
      end else if (fileHit(st.dphAddr)) begin
        hrdata[7:0] = st.regs[fileIdx(st.dphAddr)];
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence execOf(aab_op_e o);
    doExec && execOp == o;
  endsequence

  localparam int TickGap   = OSC_PER_CYCLE;
  localparam int TickQuiet = OSC_PER_CYCLE - 1;

  sequence nextTick;
    ##TickGap tick;
  endsequence

  sequence earlyTick;
    ##[1:TickQuiet] tick;
  endsequence

  sequence skipArmed;
    st.armed && !st.pending;
  endsequence

  tick_period_a: assert property (tick |-> nextTick) // RQ9
    else $error("instruction cycle length wrong");

  tick_quiet_a: assert property (tick |-> not earlyTick) // RQ9
    else $error("instruction cycle ended early");

  add_literal_a: assert property (execOf(ADD_LITERAL_OP) |=> // RQ1
    st.acc == 8'($past(st.acc) + $past(st.cmd.literal)) && !st.pending)
    else $error("add literal result wrong");

  add_carry_a: assert property (execOf(ADD_LITERAL_OP) |=> // RQ10
    st.carry == (({1'b0, $past(st.acc)} + {1'b0, $past(st.cmd.literal)}) > 9'h0FF)
    && st.zero == (st.acc == 8'h00))
    else $error("add flags wrong");

  add_register_a: assert property (execOf(ADD_REGISTER_OP) && st.cmd.target |=> // RQ2
    st.regs[$past(st.cmd.addr)] == 8'($past(st.acc) + $past(operand))
    && st.acc == $past(st.acc))
    else $error("add register target wrong");

  mask_flags_a: assert property (execOf(MASK_LITERAL_OP) |=> // RQ3
    st.acc == ($past(st.acc) & $past(st.cmd.literal)) && $stable(st.carry)
    && $stable(st.nibbleOverflowFlag))
    else $error("mask literal wrong");

  mask_register_a: assert property (execOf(MASK_REGISTER_OP) && !st.cmd.target |=> // RQ4
    st.acc == ($past(st.acc) & $past(operand)) && $stable(st.carry))
    else $error("mask register wrong");

  bit_clear_a: assert property (execOf(BIT_CLEAR_OP) |=> // RQ5
    st.regs[$past(st.cmd.addr)] == ($past(operand) & ~(8'h01 << $past(st.cmd.bitPos)))
    && $stable(st.zero) && $stable(st.acc))
    else $error("bit clear wrong");

  bit_set_a: assert property (execOf(BIT_SET_OP) |=> // RQ6
    st.regs[$past(st.cmd.addr)] == ($past(operand) | (8'h01 << $past(st.cmd.bitPos)))
    && $stable(st.carry))
    else $error("bit set wrong");

  skip_taken_a: assert property (execOf(TEST_SKIP_IF_ONE_OP) && operand[st.cmd.bitPos] // RQ7
    |=> skipArmed)
    else $error("skip did not arm");

  // Armed slot runs idle: pending and armed clear while acc, regs and zero hold
  skip_idle_a: assert property (doExec && st.armed |=> // RQ7
    !st.armed && !st.pending && $stable(st.acc) && $stable(st.regs) && $stable(st.zero))
    else $error("skip did not idle next instruction");

  skip_not_a: assert property (execOf(TEST_SKIP_IF_ONE_OP) && !operand[st.cmd.bitPos]
    |=> !st.armed && $stable(st.zero) && $stable(st.carry)) // RQ8
    else $error("untaken skip changed state");

endmodule

// File: tb/aab_core_test.sv
// Self-checking AHB-Lite bench for the accumulator datapath
module aab_core_test
  import aab_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // Long cycle so the settle bound is visible
  localparam int OPC = 16;
  logic        clk_sys;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic [31:0] rdv;
  int          mismatches;
  int          checked;
  int          polls;

  aab_core #(.OSC_PER_CYCLE(OPC)) i_dut (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic edgeReady();
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        mismatches++;
        end_sim();
      end
      @(posedge clk_sys);
    end
  endtask

  // Read data is taken at the edge that ends the data phase
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    edgeReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    edgeReady();
    rdv = hrdata;
  endtask

  task automatic look(input string what, input logic [31:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, rdv, exp);
    chk("resp", 32'(hresp), 32'h0);
  endtask

  function automatic logic [31:0] fa(input int n);
    return AAB_OFS_FILE_BASE + 32'(4 * n);
  endfunction

  // Writes a command, then polls until the busy flag drops
  task automatic exec(input aab_op_e op, input logic t, input logic [2:0] b,
                      input logic [6:0] ad, input logic [7:0] lit);
    xfer(1'b1, AAB_OFS_CMD, {8'h00, lit, 1'b0, ad, 1'b0, b, t, op});
    polls = 0;
    do begin
      xfer(1'b0, AAB_OFS_STAT, 32'h0);
      polls++;
    end while (rdv[AAB_STAT_BUSY] !== 1'b0 && polls < 40);
    if (polls >= 40) begin
      mismatches++;
      end_sim();
    end
  endtask

  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mismatches = 0;
    checked = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    look("stat", AAB_OFS_STAT, 32'h0);
    look("file", AAB_OFS_FILE_LAST, 32'h0);
    xfer(1'b1, 32'h0000_0100, 32'hFFFF_FFFF);
    look("unmapped", 32'h0000_0100, 32'h0);
    $display("reset test done");
    xfer(1'b1, AAB_OFS_STAT, 32'h0000_008F);
    exec(ADD_LITERAL_OP, 1'b0, 3'h0, 7'h00, 8'h71);
    look("add lit", AAB_OFS_STAT, 32'h0000_0700);
    chk("settle", 32'(polls <= OPC / 2 + 1), 32'h1);
    exec(ADD_LITERAL_OP, 1'b0, 3'h0, 7'h00, 8'h05);
    look("add lit", AAB_OFS_STAT, 32'h0000_0005);
    xfer(1'b1, fa(127), 32'h0000_0028);
    xfer(1'b1, AAB_OFS_STAT, 32'h0000_0019);
    exec(ADD_REGISTER_OP, 1'b1, 3'h0, 7'h7F, 8'h00);
    look("add reg file", fa(127), 32'h0000_0041);
    look("add reg stat", AAB_OFS_STAT, 32'h0000_0219);
    exec(ADD_REGISTER_OP, 1'b0, 3'h0, 7'h7F, 8'h00);
    look("add reg acc", AAB_OFS_STAT, 32'h0000_005A);
    $display("add test done");
    xfer(1'b1, AAB_OFS_STAT, 32'h0000_030F);
    exec(MASK_LITERAL_OP, 1'b0, 3'h0, 7'h00, 8'hF0);
    look("mask lit", AAB_OFS_STAT, 32'h0000_0700);
    xfer(1'b1, fa(3), 32'h0000_003C);
    xfer(1'b1, AAB_OFS_STAT, 32'h0000_00F0);
    exec(MASK_REGISTER_OP, 1'b1, 3'h0, 7'h03, 8'h00);
    look("mask file", fa(3), 32'h0000_0030);
    look("mask stat", AAB_OFS_STAT, 32'h0000_00F0);
    exec(MASK_REGISTER_OP, 1'b0, 3'h0, 7'h03, 8'h00);
    look("mask acc", AAB_OFS_STAT, 32'h0000_0030);
    $display("mask test done");
    xfer(1'b1, AAB_OFS_STAT, 32'h0000_0755);
    for (int b = 0; b < 8; b++) begin
      exec(BIT_SET_OP, 1'b0, 3'(b), 7'h09, 8'h00);
      look("bit set", fa(9), 32'((1 << (b + 1)) - 1));
    end
    for (int b = 0; b < 8; b++) begin
      exec(BIT_CLEAR_OP, 1'b0, 3'(b), 7'h09, 8'h00);
      look("bit clear", fa(9), 32'(8'(8'hFF << (b + 1))));
    end
    look("bit flags", AAB_OFS_STAT, 32'h0000_0755);
    $display("bit test done");
    xfer(1'b1, fa(9), 32'h0000_0080);
    exec(TEST_SKIP_IF_ONE_OP, 1'b0, 3'h7, 7'h09, 8'h00);
    look("skip armed", AAB_OFS_STAT, 32'h0000_1755);
    exec(ADD_LITERAL_OP, 1'b0, 3'h0, 7'h00, 8'h01);
    look("skipped", AAB_OFS_STAT, 32'h0000_0755);
    exec(TEST_SKIP_IF_ONE_OP, 1'b0, 3'h0, 7'h09, 8'h00);
    look("no skip", AAB_OFS_STAT, 32'h0000_0755);
    exec(ADD_LITERAL_OP, 1'b0, 3'h0, 7'h00, 8'h01);
    look("after test", AAB_OFS_STAT, 32'h0000_0056);
    look("cmd back", AAB_OFS_CMD, 32'h0001_0001);
    $display("skip test done");
    end_sim();
  end
endmodule
